/* sim/fsw_host_model.sv */
// Host controller model that issues decoded SPI frames as strobes.
// Assumes callers enter its tasks just after a falling clock edge.
`timescale 1ns/100ps
module fsw_host_model #(
  parameter int GAP = 2
) (
  input wire logic mclk,
  output logic frame_end,
  output logic status_clear_cmd,
  output logic trig_write,
  output logic trig_value,
  output logic unlock_write,
  output logic disable_write,
  output logic disable_value,
  output logic period_write,
  output logic period_value,
  output logic level_write,
  output logic level_value,
  output logic gen_detect_write,
  output logic gen_detect_value
);
  initial begin
    {frame_end, status_clear_cmd, trig_write, trig_value, unlock_write, disable_write, disable_value} = 7'h00;
    {period_write, period_value, level_write, level_value, gen_detect_write, gen_detect_value} = 6'h00;
  end
  // Sends one frame; kind 0 read, 1 clear, 2 trigger, 3 unlock, 4 disable, 5 period, 6 level, 7 generator.
  task automatic frame(input logic [2:0] kind, input logic val);
    frame_end = 1'b1;
    status_clear_cmd = (kind == 3'h1);
    trig_write = (kind == 3'h2);
    unlock_write = (kind == 3'h3);
    disable_write = (kind == 3'h4);
    period_write = (kind == 3'h5);
    level_write = (kind == 3'h6);
    gen_detect_write = (kind == 3'h7);
    {trig_value, disable_value, period_value, level_value, gen_detect_value} = {5{val}};
    @(negedge mclk);
    {frame_end, status_clear_cmd, trig_write, unlock_write, disable_write} = 5'h00;
    {period_write, level_write, gen_detect_write} = 3'h0;
    {trig_value, disable_value, period_value, level_value, gen_detect_value} = {5{~val}};
    repeat (GAP) @(negedge mclk);
  endtask
  // Leaves fail-safe with three consecutive frames.
  task automatic exit_fail_safe();
    frame(3'h1, 1'b0);
    frame(3'h2, 1'b1);
    frame(3'h2, 1'b0);
  endtask
  // Disables the watchdog with an unlock frame and then a disable frame.
  task automatic disable_watchdog();
    frame(3'h3, 1'b1);
    frame(3'h4, 1'b1);
  endtask
endmodule

/* sim/fsw_supervisor_properties.sv */
// Concurrent checks on the ports of the fault supervisor.
// Assumes it is bound into fsw_supervisor and shares its clock and reset.
`timescale 1ns/100ps
module fsw_supervisor_properties
  import fsw_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic vs_under,
  input wire logic vs_below_ov_on,
  input wire logic vcp_under,
  input wire logic frame_end,
  input wire logic status_clear_cmd,
  input wire logic trig_write,
  input wire logic trig_value,
  input wire logic drivers_enable,
  input wire logic spi_ready,
  input wire logic pump_enable,
  input wire logic supply_error_flag,
  input wire logic supply_undervoltage_flag,
  input wire logic supply_overvoltage_flag,
  input wire logic pump_undervoltage_flag,
  input wire logic global_error_flag,
  input wire logic fail_safe_flag,
  input wire logic wd_trigger_bit,
  input wire logic wd_period_select,
  input wire logic wd_disable_bit,
  input wire logic overvoltage_level_select,
  input wire logic generator_detect_enable
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  sequence pump_trip;
    $rose(vcp_under);
  endsequence
  sequence trig_same;
    frame_end && trig_write && (trig_value == wd_trigger_bit) && !fail_safe_flag && !wd_disable_bit;
  endsequence
  sequence trig_good;
    frame_end && trig_write && (trig_value != wd_trigger_bit) && !fail_safe_flag;
  endsequence
  rst_quiet_a: assert property (disable iff (1'b0) sys_rst |-> !drivers_enable && !spi_ready && !pump_enable)
    else $error("outputs active during reset");
  uv_latch_a: assert property (vs_under |-> ##[1:2] (supply_undervoltage_flag && supply_error_flag && pump_undervoltage_flag))
    else $error("undervoltage flags not set");
  drv_off_a: assert property ((supply_undervoltage_flag || supply_overvoltage_flag || fail_safe_flag) |-> !drivers_enable)
    else $error("drivers on during latched fault");
  ov_pump_a: assert property (supply_overvoltage_flag && !vs_below_ov_on |-> !pump_enable)
    else $error("pump running during overvoltage");
  uv_clear_a: assert property ($fell(supply_undervoltage_flag) |-> $past(status_clear_cmd) || $past(status_clear_cmd, 2))
    else $error("undervoltage flag cleared illegally");
  pump_clear_a: assert property ($fell(pump_undervoltage_flag) |-> ($past(status_clear_cmd) || $past(status_clear_cmd, 2)) && !vcp_under)
    else $error("pump flag cleared illegally");
  pump_trip_a: assert property (pump_trip |-> ##[1:3] (pump_undervoltage_flag && supply_error_flag && global_error_flag))
    else $error("pump undervoltage flags not set");
  trig_toggle_a: assert property (trig_good |=> wd_trigger_bit == $past(trig_value))
    else $error("valid trigger not stored");
  trig_same_a: assert property (trig_same |-> ##[1:2] fail_safe_flag)
    else $error("same trigger missed fail-safe");
  fs_default_a: assert property (fail_safe_flag && $past(fail_safe_flag) |-> !wd_period_select && !overvoltage_level_select && !generator_detect_enable)
    else $error("controls not at default during fail-safe");
endmodule

bind fsw_supervisor fsw_supervisor_properties i_chk (.*);

/* sim/fsw_supervisor_tb.sv */
// Self-checking testbench for the fault supervisor and watchdog.
// Assumes the host model for frames; comparator levels and meter pulses come from here.
`timescale 1ns/100ps
`include "fsw_consts.svh"
module fsw_supervisor_tb;
  logic mclk, sys_rst, vs_under, vs_turn_on_ok, vs_over_lvl1, vs_over_lvl2, vs_below_ov_on, vcp_under;
  logic thermal_shutdown_flag, pump_undervoltage_flag_charge_timeout, sw_cmd_on, sw_cmd_off, gate_on_seen, gate_off_seen;
  logic edge_done, blank_expired, guard_expired, frame_end, status_clear_cmd, trig_write, trig_value;
  logic unlock_write, disable_write, disable_value, period_write, period_value, level_write, level_value;
  logic gen_detect_write, gen_detect_value, drivers_enable, use_static_gate_current, pump_enable;
  logic supply_error_flag, supply_undervoltage_flag, supply_overvoltage_flag, pump_undervoltage_flag;
  logic global_error_flag, fail_safe_flag, wd_trigger_bit, wd_period_select, wd_disable_bit, generator_mode;
  logic [1:0] wd_position_status;
  logic [`FSW_MEAS_W-1:0] guard_cycles, blank_cycles, ton, toff;
  int miscompares = 0;
  int n_tests = 0;
  fsw_supervisor i_fsw_supervisor (.*, .gate_discharge(), .spi_ready(), .overvoltage_level_select(),
    .generator_detect_enable(), .switching_delay_status_on(ton), .switching_delay_status_off(toff),
    .edge_time_status_rise(), .edge_time_status_fall());
  fsw_host_model i_fsw_host_model (.*);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic finish_test();
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
    idle(3);
  endtask
  task automatic clear_status();
    i_fsw_host_model.frame(3'h1, 1'b0);
  endtask
  // Trips overvoltage at the selected level only, then recovers.
  task automatic ov_cycle(input logic lv);
    i_fsw_host_model.frame(3'h6, lv);
    vs_below_ov_on = 1'b0;
    if (lv) vs_over_lvl1 = 1'b1;
    else vs_over_lvl2 = 1'b1;
    idle(3);
    check("ov_other_level", supply_overvoltage_flag, 8'h00);
    {vs_over_lvl1, vs_over_lvl2} = 2'h3;
    idle(3);
    check("ov_flag", supply_overvoltage_flag, 8'h01);
    check("ov_pump_off", pump_enable, 8'h00);
    check("ov_drivers", drivers_enable, 8'h00);
    {vs_over_lvl1, vs_over_lvl2, vs_below_ov_on} = 3'h1;
    idle(3);
    check("ov_pump_restart", pump_enable, 8'h01);
    check("ov_drivers_held", drivers_enable, 8'h00);
    idle(700);
    clear_status();
    check("ov_cleared", supply_overvoltage_flag, 8'h00);
    idle(700);
    clear_status();
    check("ov_drivers_back", drivers_enable, 8'h01);
  endtask
  initial begin
    {vs_under, vs_over_lvl1, vs_over_lvl2, vcp_under, thermal_shutdown_flag, pump_undervoltage_flag_charge_timeout} = 6'h00;
    {sw_cmd_on, sw_cmd_off, gate_on_seen, gate_off_seen, edge_done, blank_expired, guard_expired} = 7'h00;
    {sys_rst, vs_turn_on_ok, vs_below_ov_on} = 3'h7;
    guard_cycles = 8'h0c;
    blank_cycles = 8'h09;
    idle(20);
    sys_rst = 1'b0;
    idle(2);
    check("trig_reset", wd_trigger_bit, 8'h00);
    check("drivers_after_reset", drivers_enable, 8'h01);
    i_fsw_host_model.frame(3'h5, 1'b1);
    i_fsw_host_model.frame(3'h2, 1'b1);
    check("trig_toggled", wd_trigger_bit, 8'h01);
    check("position_first", wd_position_status, 8'h00);
    i_fsw_host_model.frame(3'h2, 1'b1);
    check("fs_same_value", fail_safe_flag, 8'h01);
    check("fs_drivers", drivers_enable, 8'h00);
    check("fs_period_default", wd_period_select, 8'h00);
    clear_status();
    i_fsw_host_model.frame(3'h0, 1'b0);
    i_fsw_host_model.frame(3'h2, 1'b1);
    i_fsw_host_model.frame(3'h2, 1'b0);
    check("fs_broken_exit", fail_safe_flag, 8'h01);
    i_fsw_host_model.exit_fail_safe();
    check("fs_exit", fail_safe_flag, 8'h00);
    check("fs_exit_drivers", drivers_enable, 8'h01);
    i_fsw_host_model.frame(3'h4, 1'b1);
    check("dis_locked", wd_disable_bit, 8'h00);
    i_fsw_host_model.frame(3'h3, 1'b1);
    i_fsw_host_model.frame(3'h0, 1'b0);
    i_fsw_host_model.frame(3'h4, 1'b1);
    check("dis_late", wd_disable_bit, 8'h00);
    i_fsw_host_model.disable_watchdog();
    check("dis_set", wd_disable_bit, 8'h01);
    i_fsw_host_model.frame(3'h4, 1'b0);
    check("dis_cleared", wd_disable_bit, 8'h00);
    {vs_under, vs_turn_on_ok} = 2'h2;
    idle(3);
    check("uv_flags", {supply_undervoltage_flag, supply_error_flag, pump_undervoltage_flag}, 8'h07);
    check("uv_drivers", drivers_enable, 8'h00);
    check("uv_static", use_static_gate_current, 8'h01);
    vs_under = 1'b0;
    idle(2);
    clear_status();
    check("uv_low_supply", supply_undervoltage_flag, 8'h01);
    vs_turn_on_ok = 1'b1;
    clear_status();
    check("uv_cleared", supply_undervoltage_flag, 8'h00);
    check("pump_hold", pump_undervoltage_flag, 8'h01);
    idle(700);
    clear_status();
    check("pump_after_hold", {pump_undervoltage_flag, supply_error_flag}, 8'h00);
    check("uv_drivers_back", drivers_enable, 8'h01);
    ov_cycle(1'b0);
    ov_cycle(1'b1);
    vcp_under = 1'b1;
    idle(3);
    check("cp_flags", {pump_undervoltage_flag, supply_error_flag, global_error_flag}, 8'h07);
    idle(20);
    check("cp_drivers", drivers_enable, 8'h00);
    clear_status();
    check("cp_low_hold", pump_undervoltage_flag, 8'h01);
    vcp_under = 1'b0;
    idle(2);
    clear_status();
    check("cp_cleared", pump_undervoltage_flag, 8'h00);
    pulse(sw_cmd_on);
    pulse(blank_expired);
    check("ton_blank", ton, blank_cycles);
    pulse(sw_cmd_off);
    pulse(guard_expired);
    check("toff_guard", toff, guard_cycles);
    check("gen_off", generator_mode, 8'h00);
    i_fsw_host_model.frame(3'h7, 1'b1);
    pulse(sw_cmd_off);
    pulse(guard_expired);
    check("gen_on", generator_mode, 8'h01);
    pulse(pump_undervoltage_flag_charge_timeout);
    check("cp_charge_slow", pump_undervoltage_flag, 8'h01);
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    finish_test();
  end
endmodule

/* verilog/fsw_consts.svh */
// Constants for the fault supervisor and watchdog block.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH
`define FSW_CLK_MHZ 10
`define FSW_WD_PER_SHORT_MS 50
`define FSW_WD_PER_LONG_MS 200
`define FSW_WD_SHORT_CYC (`FSW_WD_PER_SHORT_MS * 1000 * `FSW_CLK_MHZ)
`define FSW_WD_LONG_CYC (`FSW_WD_PER_LONG_MS * 1000 * `FSW_CLK_MHZ)
`define FSW_PUMP_UNDERVOLTAGE_FLAG_HOLD_US 64
`define FSW_PUMP_UNDERVOLTAGE_FLAG_HOLD_CYC (`FSW_PUMP_UNDERVOLTAGE_FLAG_HOLD_US * `FSW_CLK_MHZ)
`define FSW_WD_CNT_W 22
`define FSW_MEAS_W 8
`define FSW_HOLD_W 10
`define FSW_NUM_HB 8
`define FSW_TRIG_RST 1'b0
`endif

/* verilog/fsw_delay_meter.sv */
// Switching delay meter for one modulated switch.
// Assumes edge and threshold events are synchronous one-cycle pulses.
`timescale 1ns/100ps
`include "fsw_consts.svh"
module fsw_delay_meter
  import fsw_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic gen_detect_en,
  input wire logic cmd_on,
  input wire logic cmd_off,
  input wire logic gate_on_seen,
  input wire logic gate_off_seen,
  input wire logic edge_done,
  input wire logic blank_expired,
  input wire logic guard_expired,
  input wire logic [`FSW_MEAS_W-1:0] blank_cycles,
  input wire logic [`FSW_MEAS_W-1:0] guard_cycles,
  output logic [`FSW_MEAS_W-1:0] ton_delay,
  output logic [`FSW_MEAS_W-1:0] toff_delay,
  output logic [`FSW_MEAS_W-1:0] rise_time,
  output logic [`FSW_MEAS_W-1:0] fall_time,
  output logic generator_mode
);
  fsw_meas_e st_ff;
  logic dir_on_ff;
  logic [`FSW_MEAS_W-1:0] cnt_ff;
  logic [`FSW_MEAS_W-1:0] mark_ff;

  // Counts from a command edge through the delay and then the slope.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= FSW_MS_IDLE;
      dir_on_ff <= 1'b0;
      cnt_ff <= 8'h00;
      mark_ff <= 8'h00;
    end else begin
      case (st_ff)
        FSW_MS_IDLE: begin
          if (cmd_on || cmd_off) begin
            st_ff <= FSW_MS_RUN;
            dir_on_ff <= cmd_on;
            cnt_ff <= 8'h00;
          end
        end
        FSW_MS_RUN: begin
          if (cnt_ff != 8'hff) begin
            cnt_ff <= cnt_ff + 8'h01;
          end
          if ((dir_on_ff && gate_on_seen) || (!dir_on_ff && gate_off_seen)) begin
            mark_ff <= cnt_ff;
            st_ff <= FSW_MS_DONE;
          end else if (dir_on_ff && blank_expired) begin
            mark_ff <= blank_cycles;
            st_ff <= FSW_MS_IDLE;
          end else if (!dir_on_ff && guard_expired) begin
            st_ff <= FSW_MS_IDLE;
          end
        end
        FSW_MS_DONE: begin
          if (cnt_ff != 8'hff) begin
            cnt_ff <= cnt_ff + 8'h01;
          end
          if (edge_done) begin
            st_ff <= FSW_MS_IDLE;
          end
        end
        default: st_ff <= FSW_MS_IDLE;
      endcase
    end
  end

  // Latches the measured delays and slopes.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ton_delay <= 8'h00;
      toff_delay <= 8'h00;
      rise_time <= 8'h00;
      fall_time <= 8'h00;
      generator_mode <= 1'b0;
    end else begin
      if (st_ff == FSW_MS_RUN && dir_on_ff) begin
        if (gate_on_seen) begin
          ton_delay <= cnt_ff;
        end else if (blank_expired) begin
          ton_delay <= blank_cycles; // RL12
        end
      end
      if (st_ff == FSW_MS_RUN && !dir_on_ff) begin
        if (gate_off_seen) begin
          toff_delay <= cnt_ff;
          generator_mode <= 1'b0;
        end else if (guard_expired && !gen_detect_en) begin
          toff_delay <= guard_cycles; // RL13
        end else if (guard_expired && gen_detect_en) begin
          generator_mode <= 1'b1; // RL14
        end
      end
      if (st_ff == FSW_MS_DONE && edge_done) begin
        if (dir_on_ff) begin
          rise_time <= cnt_ff - mark_ff; // RL11
        end else begin
          fall_time <= cnt_ff - mark_ff; // RL11
        end
      end
    end
  end
endmodule

/* verilog/fsw_pkg.sv */
// Types for the fault supervisor and watchdog block.
// Assumes nothing beyond the constants header.
package fsw_pkg;
  typedef enum logic [1:0] {
    FSW_EXIT_IDLE = 2'b00,
    FSW_EXIT_CLR = 2'b01,
    FSW_EXIT_SET = 2'b11
  } fsw_exit_e;
  typedef enum logic [1:0] {
    FSW_MS_IDLE = 2'b00,
    FSW_MS_RUN = 2'b01,
    FSW_MS_DONE = 2'b11
  } fsw_meas_e;
endpackage

/* verilog/fsw_supervisor.sv */
// Fault supervisor and timeout watchdog of the gate driver.
// Assumes SPI frames are decoded outside into one-cycle strobes; sys_rst comes from the logic-supply monitor.
`timescale 1ns/100ps
`include "fsw_consts.svh"

// Overview of operation
// [RL1] Supply undervoltage latches switches off and sets supply, undervoltage, pump flags.
// [RL2] Undervoltage flag clears on status clear with supply recovered; switches re-enable. Here drivers_enable stays low until the pump flag clears.
// [RL3] Overvoltage at selected level latches switches off, stops pump, sets three flags.
// [RL4] Pump restarts when overvoltage ends; flag clears only with status clear.
// [RL5] Supply shutdown discharges gates with the static charge current setting.
// [RL6] Logic-supply reset holds all logic reset, SPI silent, drivers off.
// [RL7] Pump undervoltage discharges for guard time, then drivers off; three flags latch. Here drivers_enable drops as the pump flag sets, at discharge start.
// [RL8] Pump flags clear on status clear only while pump voltage is good.
// [RL9] After supply or thermal recovery, pump flag clear refused for 64 us.
// [RL10] After reset, pump undervoltage reported if charging exceeds its time.
// [RL11] Turn-on, turn-off delays and rise, fall times are measured and readable.
// [RL12] Blank time expiry before turn-on measured reports blank time as delay.
// [RL13] Without generator detect, guard expiry reports guard time as turn-off delay.
// [RL14] With generator detect, guard expiry without turn-off marks generator operation.
// [RL15] Watchdog starts at reset, period by select bit, trigger resets to zero.
// [RL16] A valid trigger toggle restarts the watchdog period immediately.
// [RL17] Timeout or same-value trigger write is a watchdog failure.
// [RL18] Failure latches fail-safe, resets controls to defaults, turns switches off.
// [RL19] Fail-safe exit: clear, trigger one, trigger zero, consecutive frames only.
// [RL20] Position status gives the current quarter of the watchdog period.
// [RL21] With short period, position status is not reset by a timeout.
// [RL22] Disable needs unlock then disable in next frame; clearing disable re-enables.
// [RL23] Each trigger write is compared against the stored trigger value.
module fsw_supervisor
  import fsw_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic vs_under,
  input wire logic vs_turn_on_ok,
  input wire logic vs_over_lvl1,
  input wire logic vs_over_lvl2,
  input wire logic vs_below_ov_on,
  input wire logic vcp_under,
  input wire logic thermal_shutdown_flag,
  input wire logic pump_undervoltage_flag_charge_timeout,
  input wire logic [`FSW_MEAS_W-1:0] guard_cycles,
  input wire logic [`FSW_MEAS_W-1:0] blank_cycles,
  input wire logic frame_end,
  input wire logic status_clear_cmd,
  input wire logic trig_write,
  input wire logic trig_value,
  input wire logic unlock_write,
  input wire logic disable_write,
  input wire logic disable_value,
  input wire logic period_write,
  input wire logic period_value,
  input wire logic level_write,
  input wire logic level_value,
  input wire logic gen_detect_write,
  input wire logic gen_detect_value,
  input wire logic sw_cmd_on,
  input wire logic sw_cmd_off,
  input wire logic gate_on_seen,
  input wire logic gate_off_seen,
  input wire logic edge_done,
  input wire logic blank_expired,
  input wire logic guard_expired,
  output logic drivers_enable,
  output logic gate_discharge,
  output logic use_static_gate_current,
  output logic pump_enable,
  output logic spi_ready,
  output logic supply_error_flag,
  output logic supply_undervoltage_flag,
  output logic supply_overvoltage_flag,
  output logic pump_undervoltage_flag,
  output logic global_error_flag,
  output logic fail_safe_flag,
  output logic [1:0] wd_position_status,
  output logic wd_trigger_bit,
  output logic wd_period_select,
  output logic wd_disable_bit,
  output logic overvoltage_level_select,
  output logic generator_detect_enable,
  output logic [`FSW_MEAS_W-1:0] switching_delay_status_on,
  output logic [`FSW_MEAS_W-1:0] switching_delay_status_off,
  output logic [`FSW_MEAS_W-1:0] edge_time_status_rise,
  output logic [`FSW_MEAS_W-1:0] edge_time_status_fall,
  output logic generator_mode
);
  logic [`FSW_WD_CNT_W-1:0] wd_cnt_ff;
  logic [`FSW_WD_CNT_W-1:0] wd_limit;
  logic [`FSW_HOLD_W-1:0] hold_cnt_ff;
  logic [`FSW_MEAS_W-1:0] guard_cnt_ff;
  logic unlock_ff;
  logic unlock_armed_ff;
  logic pump_fault_ff;
  logic vs_over;
  logic wd_timeout;
  logic trig_same;
  logic trig_valid;
  logic wd_fail;
  logic supply_shutdown;
  fsw_exit_e exit_ff;

  // Quarter of the period a count falls into.
  function automatic logic [1:0] quarter_of(input logic [`FSW_WD_CNT_W-1:0] cnt,
                                            input logic [`FSW_WD_CNT_W-1:0] lim);
    logic [`FSW_WD_CNT_W+1:0] c4;
    c4 = {cnt, 2'b00};
    if (c4 >= {lim, 2'b00} - {2'b00, lim}) begin
      quarter_of = 2'b11;
    end else if (c4 >= {1'b0, lim, 1'b0}) begin
      quarter_of = 2'b10;
    end else if (c4 >= {2'b00, lim}) begin
      quarter_of = 2'b01;
    end else begin
      quarter_of = 2'b00;
    end
  endfunction

  assign vs_over = overvoltage_level_select ? vs_over_lvl2 : vs_over_lvl1; // RL3
  assign wd_limit = wd_period_select ? `FSW_WD_CNT_W'(`FSW_WD_LONG_CYC) : `FSW_WD_CNT_W'(`FSW_WD_SHORT_CYC);
  assign wd_timeout = !wd_disable_bit && (wd_cnt_ff >= wd_limit - `FSW_WD_CNT_W'(1)); // RL17
  assign trig_same = trig_write && (trig_value == wd_trigger_bit); // RL23
  assign trig_valid = trig_write && (trig_value != wd_trigger_bit); // RL16
  assign wd_fail = !wd_disable_bit && (wd_timeout || trig_same); // RL17
  assign supply_shutdown = supply_undervoltage_flag || supply_overvoltage_flag || thermal_shutdown_flag;
  assign spi_ready = !sys_rst; // RL6

  // Switch enable and gate discharge control.
  always_comb begin
    drivers_enable = !sys_rst && !supply_shutdown && !pump_undervoltage_flag && !fail_safe_flag; // RL1 RL6 RL18
    gate_discharge = !drivers_enable || pump_fault_ff; // RL7
    use_static_gate_current = supply_shutdown || pump_fault_ff; // RL5
    pump_enable = !sys_rst && !(supply_overvoltage_flag && !vs_below_ov_on); // RL4
  end

  // Supply undervoltage and overvoltage flags.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      supply_undervoltage_flag <= 1'b0;
      supply_overvoltage_flag <= 1'b0;
    end else begin
      if (vs_under) begin
        supply_undervoltage_flag <= 1'b1; // RL1
      end else if (status_clear_cmd && vs_turn_on_ok) begin
        supply_undervoltage_flag <= 1'b0; // RL2
      end
      if (vs_over) begin
        supply_overvoltage_flag <= 1'b1; // RL3
      end else if (status_clear_cmd && vs_below_ov_on) begin
        supply_overvoltage_flag <= 1'b0; // RL4
      end
    end
  end

  // Hold-off after a supply or thermal fault before the pump flag may clear.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_cnt_ff <= 10'h000;
    end else if (supply_shutdown) begin
      hold_cnt_ff <= `FSW_HOLD_W'(`FSW_PUMP_UNDERVOLTAGE_FLAG_HOLD_CYC); // RL9
    end else if (hold_cnt_ff != 10'h000) begin
      hold_cnt_ff <= hold_cnt_ff - 10'h001;
    end
  end

  // Pump undervoltage discharge window over the guard time.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pump_fault_ff <= 1'b0;
      guard_cnt_ff <= 8'h00;
    end else if (vcp_under && !pump_undervoltage_flag && !pump_fault_ff) begin
      pump_fault_ff <= 1'b1; // RL7
      guard_cnt_ff <= guard_cycles;
    end else if (pump_fault_ff) begin
      if (guard_cnt_ff == 8'h00) begin
        pump_fault_ff <= 1'b0;
      end else begin
        guard_cnt_ff <= guard_cnt_ff - 8'h01;
      end
    end
  end

  // Pump undervoltage, supply error and global error flags.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pump_undervoltage_flag <= 1'b0;
      supply_error_flag <= 1'b0;
      global_error_flag <= 1'b0;
    end else begin
      if (vcp_under || vs_under || vs_over || thermal_shutdown_flag || pump_undervoltage_flag_charge_timeout) begin
        pump_undervoltage_flag <= 1'b1; // RL1 RL3 RL7 RL10
        supply_error_flag <= 1'b1;
        global_error_flag <= 1'b1;
      end else if (status_clear_cmd && hold_cnt_ff == 10'h000 && !supply_shutdown) begin
        pump_undervoltage_flag <= 1'b0; // RL8 RL9
        supply_error_flag <= 1'b0;
        global_error_flag <= fail_safe_flag;
      end
      if (wd_fail) begin
        global_error_flag <= 1'b1;
      end
    end
  end

  // Watchdog counter and position status.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_cnt_ff <= 22'h000000; // RL15
      wd_position_status <= 2'b00;
    end else if (wd_disable_bit || trig_valid) begin
      wd_cnt_ff <= 22'h000000; // RL16
      wd_position_status <= 2'b00;
    end else if (wd_timeout) begin
      wd_cnt_ff <= 22'h000000;
      if (wd_period_select) begin
        wd_position_status <= 2'b00; // RL21
      end
    end else begin
      wd_cnt_ff <= wd_cnt_ff + 22'h000001;
      wd_position_status <= quarter_of(wd_cnt_ff, wd_limit); // RL20
    end
  end

  // Control bits; fail-safe forces them back to defaults.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_trigger_bit <= `FSW_TRIG_RST; // RL15
      wd_period_select <= 1'b0;
      overvoltage_level_select <= 1'b0;
      generator_detect_enable <= 1'b0;
    end else if (wd_fail) begin
      wd_trigger_bit <= `FSW_TRIG_RST; // RL18
      wd_period_select <= 1'b0;
      overvoltage_level_select <= 1'b0;
      generator_detect_enable <= 1'b0;
    end else begin
      if (trig_valid) begin
        wd_trigger_bit <= trig_value;
      end
      if (period_write && !fail_safe_flag) begin
        wd_period_select <= period_value;
      end
      if (level_write && !fail_safe_flag) begin
        overvoltage_level_select <= level_value;
      end
      if (gen_detect_write && !fail_safe_flag) begin
        generator_detect_enable <= gen_detect_value;
      end
    end
  end

  // Unlock and disable sequence.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      unlock_ff <= 1'b0;
      unlock_armed_ff <= 1'b0;
      wd_disable_bit <= 1'b0; // RL22
    end else begin
      if (frame_end) begin
        unlock_ff <= unlock_write;
        unlock_armed_ff <= unlock_ff && !unlock_write;
      end
      if (frame_end && unlock_ff && unlock_armed_ff) begin
        unlock_ff <= 1'b0;
      end
      if (disable_write && !disable_value) begin
        wd_disable_bit <= 1'b0; // RL22
      end else if (disable_write && disable_value && unlock_ff && !unlock_write) begin
        wd_disable_bit <= 1'b1; // RL22
      end
    end
  end

  // Fail-safe flag and its exit sequence.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fail_safe_flag <= 1'b0;
      exit_ff <= FSW_EXIT_IDLE;
    end else if (wd_fail && !(fail_safe_flag && exit_ff == FSW_EXIT_SET && trig_write && !trig_value)) begin
      fail_safe_flag <= 1'b1; // RL18
      exit_ff <= (fail_safe_flag && frame_end && status_clear_cmd) ? FSW_EXIT_CLR : FSW_EXIT_IDLE;
    end else if (fail_safe_flag && frame_end) begin
      case (exit_ff)
        FSW_EXIT_IDLE: exit_ff <= status_clear_cmd ? FSW_EXIT_CLR : FSW_EXIT_IDLE; // RL19
        FSW_EXIT_CLR: exit_ff <= (trig_write && trig_value) ? FSW_EXIT_SET : FSW_EXIT_IDLE; // RL19
        FSW_EXIT_SET: begin
          if (trig_write && !trig_value) begin
            fail_safe_flag <= 1'b0; // RL19
          end
          exit_ff <= FSW_EXIT_IDLE;
        end
        default: exit_ff <= FSW_EXIT_IDLE;
      endcase
    end
  end

  fsw_delay_meter u_meter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .gen_detect_en(generator_detect_enable),
    .cmd_on(sw_cmd_on),
    .cmd_off(sw_cmd_off),
    .gate_on_seen(gate_on_seen),
    .gate_off_seen(gate_off_seen),
    .edge_done(edge_done),
    .blank_expired(blank_expired),
    .guard_expired(guard_expired),
    .blank_cycles(blank_cycles),
    .guard_cycles(guard_cycles),
    .ton_delay(switching_delay_status_on),
    .toff_delay(switching_delay_status_off),
    .rise_time(edge_time_status_rise),
    .fall_time(edge_time_status_fall),
    .generator_mode(generator_mode)
  );
endmodule
